// File: hw/gpt_defines.svh
// Register offsets, field positions, reset values and counts of the timer unit
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

// ==========================================
// Global register offsets
`define GPT_OFS_START 16'h1300
`define GPT_OFS_SYNC 16'h1304
`define GPT_OFS_PWM 16'h1308
`define GPT_OFS_RSPWM 16'h131c

// ==========================================
// Channel block starting offsets
`define GPT_BASE_CH0 16'h1320
`define GPT_BASE_CH1 16'h1340
`define GPT_BASE_CH2 16'h1360
`define GPT_BASE_CH3 16'h1380
`define GPT_BASE_CH4 16'h13a0
`define GPT_BASE_CH5 16'h13d0

// ==========================================
// Register offsets inside a channel block
`define GPT_OFS_CTRL 16'h0000
`define GPT_OFS_IOCTRL 16'h0004
`define GPT_OFS_IRQEN 16'h0008
`define GPT_OFS_FLAG 16'h000c
`define GPT_OFS_CNT 16'h0010
`define GPT_OFS_GRA 16'h0014
`define GPT_OFS_GRB 16'h0018

// ==========================================
// Reset values
`define GPT_RST_START 8'hc0
`define GPT_RST_SYNC 8'hc0
`define GPT_RST_PWM 8'hc0
`define GPT_RST_CTRL 8'h98
`define GPT_RST_IOCTRL 8'h88
`define GPT_RST_IRQEN 8'hf8
`define GPT_FLAG_RES 8'hf8

// ==========================================
// Field positions
`define GPT_CLR_LSB 5
`define GPT_SRC_LSB 0
`define GPT_IOA_LSB 0
`define GPT_IOB_LSB 4
`define GPT_BIT_A 0
`define GPT_BIT_B 1
`define GPT_BIT_OVF 2

// ==========================================
// Counts
`define GPT_CNT_MAX 16'hffff
`define GPT_PRE_BITS 6

`endif

// File: hw/gpt_pkg.sv
// Types shared by the timer unit modules
package gpt_pkg;

  // Counter clear source selection
  typedef enum logic [1:0] {
    GPT_CLR_NONE = 2'h0,
    GPT_CLR_A = 2'h1,
    GPT_CLR_B = 2'h2,
    GPT_CLR_SYNC = 2'h3
  } gpt_clr_t;

  // Pin function of a general register
  typedef enum logic [2:0] {
    GPT_IO_OFF = 3'h0,
    GPT_IO_OUT0 = 3'h1,
    GPT_IO_OUT1 = 3'h2,
    GPT_IO_TOG = 3'h3,
    GPT_IO_CAPR = 3'h4,
    GPT_IO_CAPF = 3'h5,
    GPT_IO_CAPB = 3'h6,
    GPT_IO_NONE = 3'h7
  } gpt_io_t;

endpackage

// File: hw/gpt_tick_if.sv
// Count enables passed from the prescaler to the channels
`timescale 1ns/10ps
interface gpt_tick_if;
  logic [7:0] tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// File: hw/gpt_prescale.sv
// Prescaler: internal divided enables and external clock falling edges
`timescale 1ns/10ps
module gpt_prescale
  import gpt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] ext_clk_i,
  gpt_tick_if.src tk
);
  `include "gpt_defines.svh"

  logic [`GPT_PRE_BITS-1:0] div_r;
  logic [3:0] ext_prev_r;

  // ==========================================
  // Free divider of the reference clock
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_r <= '0;
    else
      div_r <= div_r + 6'h01;
  end

  // Previous level of the external clocks, for falling edge detection
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ext_prev_r <= 4'hf;
    else
      ext_prev_r <= ext_clk_i;
  end

  // A divided clock falls when its low bits all wrap, one pulse per period
  assign tk.tick[0] = (div_r[0] == 1'h1);
  assign tk.tick[1] = (div_r[1:0] == 2'h3);
  assign tk.tick[2] = (div_r[3:0] == 4'hf);
  assign tk.tick[3] = (div_r[5:0] == 6'h3f);
  assign tk.tick[7:4] = ext_prev_r & ~ext_clk_i;

endmodule // gpt_prescale

// File: hw/gpt_top.sv
// Six-channel 16-bit timer unit with compare, capture, sync and PWM
//
// Operation
// - Reset leaves channels free running, start counts
// - Wrap from max to zero sets overflow
// - Overflow requests interrupt only when enabled
// - Counter continues from zero after overflow
// - Match clear source makes periodic counter
// - Match sets flag; clears counter if selected
// - Match flag requests interrupt only when enabled
// - Compare match drives pin one, zero, toggle
// - Selected pin edge captures counter into register
// - Capture sets flag, interrupt when enabled
// - Capture clear source clears counter on edge
// - Sync channel clear clears all sync channels
// - Counter write copies to all sync channels
// - PWM mode makes pin A an output
// - PWM pin high on A match, low B
// - PWM works free running and synchronized
// - Reset-sync PWM toggles on channel 1 counter
// - Count on falling edge of selected source
// - Sync bit joins channel, else independent
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module gpt_top
  import gpt_pkg::*;
#(
  parameter int CH_N = 6
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [3:0] ext_clk_i,
  input wire logic [CH_N-1:0] pin_a_i,
  output logic [CH_N-1:0] pin_a_o,
  output logic [CH_N-1:0] pin_a_oe_o,
  input wire logic [CH_N-1:0] pin_b_i,
  output logic [CH_N-1:0] pin_b_o,
  output logic [CH_N-1:0] pin_b_oe_o,
  output logic [CH_N-1:0] irq_ovf_o,
  output logic [CH_N-1:0] irq_a_o,
  output logic [CH_N-1:0] irq_b_o
);
  `include "gpt_defines.svh"

  // Reset-sync PWM uses channels 1 to 3; the map only holds six blocks
  if (CH_N < 4 || CH_N > 6)
  begin : g_bad_ch_n
    $error("CH_N must be between 4 and 6");
  end

  // ==========================================
  // Address decoding helpers
  function automatic logic [15:0] ch_base(input int n);
    case (n)
      0: ch_base = `GPT_BASE_CH0;
      1: ch_base = `GPT_BASE_CH1;
      2: ch_base = `GPT_BASE_CH2;
      3: ch_base = `GPT_BASE_CH3;
      4: ch_base = `GPT_BASE_CH4;
      default: ch_base = `GPT_BASE_CH5;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [15:0] a, input int n, input logic [15:0] ofs);
    reg_hit = (a == 16'(ch_base(n) + ofs));
  endfunction

  function automatic logic io_is_out(input gpt_io_t m);
    io_is_out = (m == GPT_IO_OUT0) || (m == GPT_IO_OUT1) || (m == GPT_IO_TOG);
  endfunction

  function automatic logic io_is_cap(input gpt_io_t m);
    io_is_cap = (m == GPT_IO_CAPR) || (m == GPT_IO_CAPF) || (m == GPT_IO_CAPB);
  endfunction

  // Capture edge qualifier for the chosen polarity
  function automatic logic cap_edge(input gpt_io_t m, input logic rise, input logic fall);
    case (m)
      GPT_IO_CAPR: cap_edge = rise;
      GPT_IO_CAPF: cap_edge = fall;
      GPT_IO_CAPB: cap_edge = rise | fall;
      default: cap_edge = 1'b0;
    endcase
  endfunction

  // Next level of a compare output on a match
  function automatic logic cmp_level(input gpt_io_t m, input logic cur);
    case (m)
      GPT_IO_OUT0: cmp_level = 1'b0;
      GPT_IO_OUT1: cmp_level = 1'b1;
      GPT_IO_TOG: cmp_level = ~cur;
      default: cmp_level = cur;
    endcase
  endfunction

  // ==========================================
  // Global registers and prescaler
  logic [7:0] start_r;
  logic [7:0] sync_r;
  logic [7:0] pwm_r;
  logic rspwm_r;
  logic [31:0] rdata_nxt;
  logic [CH_N-1:0] own_clr;
  logic [CH_N-1:0] cnt_wr_hit;
  logic sync_clr;
  logic sync_wr;
  logic [15:0] cnt_w [CH_N];
  logic [15:0] gra_w [CH_N];
  logic [15:0] grb_w [CH_N];
  logic [7:0] ctrl_w [CH_N];
  logic [7:0] ioctrl_w [CH_N];
  logic [7:0] irqen_w [CH_N];
  logic [2:0] flag_w [CH_N];
  logic [CH_N-1:0] clr_w;
  logic rs_tog;

  gpt_tick_if tk_if ();

  gpt_prescale u_prescale (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ext_clk_i(ext_clk_i),
    .tk(tk_if.src)
  );

  // Run, sync and PWM selections, one bit per channel
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      start_r <= `GPT_RST_START;
      sync_r <= `GPT_RST_SYNC;
      pwm_r <= `GPT_RST_PWM;
      rspwm_r <= 1'b0;
    end
    else if (wr_i)
    begin
      if (addr_i == `GPT_OFS_START)
        start_r <= wdata_i[7:0];
      if (addr_i == `GPT_OFS_SYNC)
        sync_r <= wdata_i[7:0];
      if (addr_i == `GPT_OFS_PWM)
        pwm_r <= wdata_i[7:0];
      if (addr_i == `GPT_OFS_RSPWM)
        rspwm_r <= wdata_i[0];
    end
  end

  // Synchronized clear and write reach every channel of the sync group
  assign sync_clr = |(own_clr & sync_r[CH_N-1:0]);
  assign sync_wr = wr_i && (|(cnt_wr_hit & sync_r[CH_N-1:0]));
  // Reset-sync PWM toggles each PWM-mode channel 1..3 output when counter 1 clears
  assign rs_tog = rspwm_r && clr_w[1];

  // ==========================================
  // Channels
  for (genvar n = 0; n < CH_N; n++)
  begin : g_ch
    logic [15:0] cnt_r;
    logic [15:0] gra_r;
    logic [15:0] grb_r;
    logic [7:0] ctrl_r;
    logic [7:0] ioctrl_r;
    logic [7:0] irqen_r;
    logic [2:0] flag_r;
    logic pa_r;
    logic pb_r;
    logic pa_prev_r;
    logic pb_prev_r;
    logic tick;
    logic cnt_en;
    logic cmp_a;
    logic cmp_b;
    logic cap_a;
    logic cap_b;
    logic ovf;
    logic clr;
    logic rs_b;
    gpt_io_t ioa;
    gpt_io_t iob;
    gpt_clr_t csel;

    assign ioa = gpt_io_t'(ctrl_io_a(ioctrl_r));
    assign iob = gpt_io_t'(ioctrl_r[`GPT_IOB_LSB +: 3]);
    assign csel = gpt_clr_t'(ctrl_r[`GPT_CLR_LSB +: 2]);
    assign tick = tk_if.tick[ctrl_r[`GPT_SRC_LSB +: 3]];
    assign cnt_en = start_r[n] && tick;
    // Matches count only while running; PWM compares on both registers
    assign cmp_a = cnt_en && (cnt_r == gra_r) && (io_is_out(ioa) || pwm_r[n]);
    assign cmp_b = cnt_en && (cnt_r == grb_r) && (io_is_out(iob) || pwm_r[n]);
    assign cap_a = !pwm_r[n] && cap_edge(ioa, pin_a_i[n] & ~pa_prev_r, ~pin_a_i[n] & pa_prev_r);
    assign cap_b = cap_edge(iob, pin_b_i[n] & ~pb_prev_r, ~pin_b_i[n] & pb_prev_r);
    assign own_clr[n] = ((csel == GPT_CLR_A) && (cmp_a || cap_a))
                      || ((csel == GPT_CLR_B) && (cmp_b || cap_b));
    assign clr = own_clr[n] || (sync_r[n] && sync_clr);
    assign ovf = cnt_en && !clr && (cnt_r == `GPT_CNT_MAX);
    assign cnt_wr_hit[n] = reg_hit(addr_i, n, `GPT_OFS_CNT);
    // Channels 1..3 in reset-sync PWM toggle on their B against counter 1
    assign rs_b = rspwm_r && (n >= 1) && (n <= 3) && cnt_w_en1(n) && (cnt_w[1] == grb_r);

    // Previous pin levels for capture edge detection
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        pa_prev_r <= 1'b0;
        pb_prev_r <= 1'b0;
      end
      else
      begin
        pa_prev_r <= pin_a_i[n];
        pb_prev_r <= pin_b_i[n];
      end
    end

    // Control registers of the channel
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        ctrl_r <= `GPT_RST_CTRL;
        ioctrl_r <= `GPT_RST_IOCTRL;
        irqen_r <= `GPT_RST_IRQEN;
      end
      else if (wr_i)
      begin
        if (reg_hit(addr_i, n, `GPT_OFS_CTRL))
          ctrl_r <= wdata_i[7:0];
        if (reg_hit(addr_i, n, `GPT_OFS_IOCTRL))
          ioctrl_r <= wdata_i[7:0];
        if (reg_hit(addr_i, n, `GPT_OFS_IRQEN))
          irqen_r <= wdata_i[7:0];
      end
    end

    // Counter: sync write, then clear, then count; overflow rolls to zero
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        cnt_r <= '0;
      else if ((wr_i && cnt_wr_hit[n]) || (sync_r[n] && sync_wr))
        cnt_r <= wdata_i[15:0];
      else if (clr)
        cnt_r <= '0;
      else if (cnt_en)
        cnt_r <= 16'(cnt_r + 16'h0001);
    end

    // General registers: capture takes priority over a software write
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        gra_r <= `GPT_CNT_MAX;
        grb_r <= `GPT_CNT_MAX;
      end
      else
      begin
        if (cap_a)
          gra_r <= cnt_r;
        else if (wr_i && reg_hit(addr_i, n, `GPT_OFS_GRA))
          gra_r <= wdata_i[15:0];
        if (cap_b)
          grb_r <= cnt_r;
        else if (wr_i && reg_hit(addr_i, n, `GPT_OFS_GRB))
          grb_r <= wdata_i[15:0];
      end
    end

    // Sticky flags, cleared by writing one; a new event wins the clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        flag_r <= '0;
      else
      begin
        if (wr_i && reg_hit(addr_i, n, `GPT_OFS_FLAG))
          flag_r <= flag_r & ~wdata_i[2:0];
        if (cmp_a || cap_a)
          flag_r[`GPT_BIT_A] <= 1'b1;
        if (cmp_b || cap_b)
          flag_r[`GPT_BIT_B] <= 1'b1;
        if (ovf)
          flag_r[`GPT_BIT_OVF] <= 1'b1;
      end
    end

    // Pin outputs: PWM, reset-sync PWM or compare match actions
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        pa_r <= 1'b0;
        pb_r <= 1'b0;
      end
      else
      begin
        if (pwm_r[n] && rspwm_r && (n >= 1) && (n <= 3))
        begin
          if (rs_b ^ rs_tog)
            pa_r <= ~pa_r;
        end
        else if (pwm_r[n])
        begin
          if (cmp_b)
            pa_r <= 1'b0;
          else if (cmp_a)
            pa_r <= 1'b1;
        end
        else if (cmp_a)
          pa_r <= cmp_level(ioa, pa_r);
        if (cmp_b && !pwm_r[n])
          pb_r <= cmp_level(iob, pb_r);
      end
    end

    assign pin_a_o[n] = pa_r;
    assign pin_a_oe_o[n] = pwm_r[n] || io_is_out(ioa);
    assign pin_b_o[n] = pb_r;
    assign pin_b_oe_o[n] = !pwm_r[n] && io_is_out(iob);
    assign irq_ovf_o[n] = flag_r[`GPT_BIT_OVF] && irqen_r[`GPT_BIT_OVF];
    assign irq_a_o[n] = flag_r[`GPT_BIT_A] && irqen_r[`GPT_BIT_A];
    assign irq_b_o[n] = flag_r[`GPT_BIT_B] && irqen_r[`GPT_BIT_B];
    assign cnt_w[n] = cnt_r;
    assign gra_w[n] = gra_r;
    assign grb_w[n] = grb_r;
    assign ctrl_w[n] = ctrl_r;
    assign ioctrl_w[n] = ioctrl_r;
    assign irqen_w[n] = irqen_r;
    assign flag_w[n] = flag_r;
    assign clr_w[n] = clr;
  end

  // Pin A function field of a channel I/O control value
  function automatic logic [2:0] ctrl_io_a(input logic [7:0] v);
    ctrl_io_a = v[`GPT_IOA_LSB +: 3];
  endfunction

  // Counter 1 compare is only meaningful on its own running ticks
  function automatic logic cnt_w_en1(input int n);
    cnt_w_en1 = start_r[1] && tk_if.tick[ctrl_w[1][`GPT_SRC_LSB +: 3]] && (n != 0);
  endfunction

  // ==========================================
  // Read path: data stands in the cycle after the read strobe
  always_comb
  begin
    rdata_nxt = '0;
    if (addr_i == `GPT_OFS_START)
      rdata_nxt = {24'h0, start_r};
    else if (addr_i == `GPT_OFS_SYNC)
      rdata_nxt = {24'h0, sync_r};
    else if (addr_i == `GPT_OFS_PWM)
      rdata_nxt = {24'h0, pwm_r};
    else if (addr_i == `GPT_OFS_RSPWM)
      rdata_nxt = {31'h0, rspwm_r};
    for (int n = 0; n < CH_N; n++)
    begin
      if (reg_hit(addr_i, n, `GPT_OFS_CTRL))
        rdata_nxt = {24'h0, ctrl_w[n]};
      if (reg_hit(addr_i, n, `GPT_OFS_IOCTRL))
        rdata_nxt = {24'h0, ioctrl_w[n]};
      if (reg_hit(addr_i, n, `GPT_OFS_IRQEN))
        rdata_nxt = {24'h0, irqen_w[n]};
      if (reg_hit(addr_i, n, `GPT_OFS_FLAG))
        rdata_nxt = {24'h0, `GPT_FLAG_RES | {5'h00, flag_w[n]}};
      if (reg_hit(addr_i, n, `GPT_OFS_CNT))
        rdata_nxt = {16'h0, cnt_w[n]};
      if (reg_hit(addr_i, n, `GPT_OFS_GRA))
        rdata_nxt = {16'h0, gra_w[n]};
      if (reg_hit(addr_i, n, `GPT_OFS_GRB))
        rdata_nxt = {16'h0, grb_w[n]};
    end
  end

  // Read data register; unmapped addresses answer zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else if (rd_i)
      rdata_o <= rdata_nxt;
    else
      rdata_o <= '0;
  end

endmodule // gpt_top

// File: bench/gpt_top_asserts.sv
// Port-level assertions for the timer unit, bound to its top module
`timescale 1ns/10ps
module gpt_top_asserts
#(
  parameter int CH_N = 6
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [CH_N-1:0] pin_a_oe_o,
  input wire logic [CH_N-1:0] irq_ovf_o,
  input wire logic [CH_N-1:0] irq_a_o,
  input wire logic [CH_N-1:0] irq_b_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========
  // Sequences
  // Enable bit of channel 0 written off, then a quiet cycle (covers a registered request)
  sequence s_en_off(int b);
    wr_i && addr_i == 16'h1328 && !wdata_i[b] ##1 !wr_i;
  endsequence
  // ==========
  // Properties
  property p_rst_quiet;
    $rose(rst_n_i) |-> {irq_ovf_o, irq_a_o, irq_b_o, pin_a_oe_o} == '0;
  endproperty
  property p_ovf_gate;
    s_en_off(2) |=> !irq_ovf_o[0];
  endproperty
  property p_a_gate;
    s_en_off(0) |=> !irq_a_o[0];
  endproperty
  property p_b_gate;
    s_en_off(1) |=> !irq_b_o[0];
  endproperty
  // Requests only drop after software touched a register
  property p_irq_hold;
    !wr_i [*2] |=> ({irq_ovf_o, irq_a_o, irq_b_o} & $past({irq_ovf_o, irq_a_o, irq_b_o}))
      == $past({irq_ovf_o, irq_a_o, irq_b_o});
  endproperty
  property p_pwm_oe;
    wr_i && addr_i == 16'h1308 |=> (pin_a_oe_o & $past(wdata_i[CH_N-1:0]))
      == $past(wdata_i[CH_N-1:0]);
  endproperty
  property p_rd_idle;
    !rd_i |=> rdata_o == 32'h0;
  endproperty
  property p_unmapped;
    rd_i && addr_i == 16'h1310 |=> rdata_o == 32'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request unmasked");
  a_a_gate: assert property (p_a_gate) else $error("match A request unmasked");
  a_b_gate: assert property (p_b_gate) else $error("match B request unmasked");
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped alone");
  a_pwm_oe: assert property (p_pwm_oe) else $error("pwm pin not driven");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // gpt_top_asserts

bind gpt_top gpt_top_asserts #(.CH_N(CH_N)) u_chk (.ref_clk_i, .rst_n_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .pin_a_oe_o, .irq_ovf_o, .irq_a_o, .irq_b_o);

// File: bench/gpt_pin_model.sv
// Pin-side partner: capture drive, pin wire levels and external count clocks
`timescale 1ns/10ps
module gpt_pin_model
#(
  parameter int EXT_HALF = 4
)
(
  input wire logic ref_clk_i,
  input wire logic [5:0] a_out_i,
  input wire logic [5:0] a_oe_i,
  input wire logic [5:0] b_out_i,
  input wire logic [5:0] b_oe_i,
  output logic [5:0] a_lvl_o,
  output logic [5:0] b_lvl_o,
  output logic [3:0] ext_o
);
  logic [5:0] drv_a = 6'h00;
  logic [3:0] ext_r = 4'hf; // Idle high, so reset brings no false fall
  int n_r = 0;
  // Wire level: the timer wins where it drives; pin B lines are pulled up
  assign a_lvl_o = (a_oe_i & a_out_i) | (~a_oe_i & drv_a);
  assign b_lvl_o = (b_oe_i & b_out_i) | ~b_oe_i;
  assign ext_o = ext_r;
  // Count clocks run free; a slow period keeps falling edges far apart
  always @(posedge ref_clk_i)
  begin
    n_r <= (n_r == EXT_HALF - 1) ? 0 : n_r + 1;
    if (n_r == EXT_HALF - 1)
      ext_r <= ~ext_r;
  end
  // Flip one capture line; called just after a rising edge
  task automatic flip_a(input int c);
    drv_a[c] <= ~drv_a[c];
  endtask
endmodule // gpt_pin_model

// File: bench/test_gpt_top.sv
// Self-checking bench for the six-channel timer unit
`timescale 1ns/10ps
module test_gpt_top
  import gpt_pkg::*;
;
  logic ref_clk_i;
  logic rst_n_i;
  logic wr_i;
  logic rd_i;
  logic pa;
  logic [15:0] addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [3:0] ext_clk_i;
  logic [5:0] pin_a_i, pin_a_o, pin_a_oe_o, pin_b_i, pin_b_o, pin_b_oe_o;
  logic [5:0] irq_ovf_o, irq_a_o, irq_b_o;
  int err_count = 0;
  int samples_checked = 0;
  // Tables: reset reads, pin modes, pwm settings, count rates
  localparam logic [15:0] RA [11] = '{16'h1300, 16'h1304, 16'h1308, 16'h1320, 16'h1324,
    16'h1328, 16'h132c, 16'h1330, 16'h1334, 16'h1338, 16'h1310};
  localparam logic [31:0] RV [11] = '{32'hc0, 32'hc0, 32'hc0, 32'h98, 32'h88, 32'hf8,
    32'hf8, 32'h0, 32'hffff, 32'hffff, 32'h0};
  localparam gpt_io_t CMP_IO [3] = '{GPT_IO_OUT1, GPT_IO_OUT0, GPT_IO_TOG};
  localparam gpt_io_t CAP_IO [3] = '{GPT_IO_CAPR, GPT_IO_CAPF, GPT_IO_CAPB};
  localparam int PC [3] = '{32'h40, 32'h40, 32'h20};
  localparam int PA [3] = '{2, 8, 6};
  localparam int PB [3] = '{6, 6, 8};
  localparam int PL [3] = '{60, 0, 140};
  localparam int PH [3] = '{100, 0, 140};
  localparam logic [31:0] SE [5] = '{32'd64, 32'd32, 32'd8, 32'd2, 32'd16};
  gpt_top #(.CH_N(6)) DUT (.ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .ext_clk_i, .pin_a_i, .pin_a_o, .pin_a_oe_o, .pin_b_i, .pin_b_o, .pin_b_oe_o, .irq_ovf_o,
    .irq_a_o, .irq_b_o);
  gpt_pin_model u_pins (.ref_clk_i, .a_out_i(pin_a_o), .a_oe_i(pin_a_oe_o), .b_out_i(pin_b_o),
    .b_oe_i(pin_b_oe_o), .a_lvl_o(pin_a_i), .b_lvl_o(pin_b_i), .ext_o(ext_clk_i));
  // 125 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // ==========
  // Bus cycles and checks
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", s, e, g);
      err_count++;
    end
  endtask
  task automatic ok(input string s, input logic c);
    chk(s, 32'h1, {31'h0, c});
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // A wait that ran out ends the run at once
  task automatic lim(input logic good);
    if (!good)
    begin
      $display("BAD wait expected done seen timeout");
      err_count++;
      report_and_stop();
    end
  endtask
  // Pin level just before the request rose is kept for toggle checks
  task automatic wait_a(input int c);
    int i;
    @(negedge ref_clk_i);
    for (i = 0; i < 400 && irq_a_o[c] !== 1'b1; i++)
    begin
      pa = pin_a_o[c];
      @(negedge ref_clk_i);
    end
    lim(i < 400);
  endtask
  // ==========
  // Scenarios
  task automatic s_reset();
    for (int i = 0; i < 11; i++)
    begin
      rd(RA[i]);
      chk("reset read", RV[i], d);
    end
  endtask
  task automatic s_ovf();
    int i;
    wr(16'h1320, 32'h00);
    wr(16'h1330, 32'hfff0);
    wr(16'h1300, 32'h01);
    for (i = 0; i < 60 && d[2] !== 1'b1; i++)
      rd(16'h132c);
    lim(i < 60);
    ok("ovf masked", irq_ovf_o[0] === 1'b0);
    wr(16'h1328, 32'h04);
    repeat (2) @(negedge ref_clk_i);
    ok("ovf request", irq_ovf_o[0] === 1'b1);
    rd(16'h1330);
    ok("count after wrap", d < 32'h40);
    wr(16'h132c, 32'h04);
    repeat (2) @(negedge ref_clk_i);
    ok("ovf cleared", irq_ovf_o[0] === 1'b0);
    wr(16'h1300, 32'h00);
  endtask
  // Counter stopped while the mode changes, so no match lands mid-setup
  task automatic s_cmp();
    wr(16'h1340, 32'h20);
    wr(16'h1354, 32'h04);
    wr(16'h1358, 32'h02);
    wr(16'h1348, 32'h03);
    for (int k = 0; k < 3; k++)
    begin
      wr(16'h1300, 32'h00);
      // Pin B sets high on its own B match, ahead of the A match each period
      wr(16'h1344, {25'h0, GPT_IO_OUT1, 1'b0, CMP_IO[k]});
      wr(16'h134c, 32'h01);
      wr(16'h1300, 32'h02);
      wait_a(1);
      ok("match pin", pin_a_o[1] === ((k == 2) ? !pa : (k == 0)));
      ok("pin driven", pin_a_oe_o[1] === 1'b1);
      ok("pin b match", pin_b_o[1] === 1'b1 && pin_b_oe_o[1] === 1'b1);
      ok("match b request", irq_b_o[1] === 1'b1);
      for (int j = 0; j < 4; j++)
      begin
        rd(16'h1350);
        ok("period bound", d <= 32'h4);
      end
    end
    wr(16'h1348, 32'h00);
    repeat (2) @(negedge ref_clk_i);
    ok("match masked", irq_a_o[1] === 1'b0 && irq_b_o[1] === 1'b0);
    rd(16'h134c);
    ok("flag held", d[0] === 1'b1);
  endtask
  task automatic s_cap();
    wr(16'h1360, 32'h20);
    wr(16'h1368, 32'h01);
    wr(16'h1300, 32'h04);
    for (int k = 0; k < 3; k++)
    begin
      wr(16'h1364, {29'h0, CAP_IO[k]});
      wr(16'h136c, 32'h01);
      repeat (30) @(posedge ref_clk_i);
      u_pins.flip_a(2);
      wait_a(2);
      rd(16'h1374);
      ok("captured count", d > 32'h8 && d < 32'h40);
    end
    rd(16'h1370);
    ok("cleared on edge", d < 32'h8);
    wr(16'h1300, 32'h00);
  endtask
  task automatic s_sync();
    logic [31:0] x;
    wr(16'h1304, 32'h03);
    wr(16'h1330, 32'h1234);
    rd(16'h1350);
    chk("sync write", 32'h1234, d);
    rd(16'h1390);
    chk("lone channel", 32'h0, d);
    wr(16'h1320, 32'h20);
    wr(16'h1334, 32'h1240);
    wr(16'h1324, 32'h01);
    wr(16'h1328, 32'h01);
    wr(16'h1340, 32'h60);
    wr(16'h1344, 32'h00);
    wr(16'h1300, 32'h03);
    wait_a(0);
    wr(16'h1300, 32'h00);
    rd(16'h1330);
    x = d;
    rd(16'h1350);
    chk("sync clear", x, d);
    ok("group cleared", x < 32'h8);
  endtask
  // Duty rows: half, zero (A above B), full (B above A)
  task automatic s_pwm();
    int h;
    wr(16'h1308, 32'h08);
    for (int r = 0; r < 3; r++)
    begin
      wr(16'h1300, 32'h00);
      wr(16'h1380, PC[r]);
      wr(16'h1394, PA[r]);
      wr(16'h1398, PB[r]);
      wr(16'h1390, 32'h0);
      wr(16'h1300, 32'h08);
      repeat (40) @(negedge ref_clk_i);
      ok("pwm driven", pin_a_oe_o[3] === 1'b1);
      h = 0;
      repeat (140)
      begin
        @(negedge ref_clk_i);
        h += int'(pin_a_o[3] === 1'b1);
      end
      ok("pwm duty", h >= PL[r] && h <= PH[r]);
    end
    wr(16'h1300, 32'h00);
  endtask
  // Reset-sync PWM on channels 1, 2: counter 1 period of 10 ticks, two toggles each
  // Channel 1 stays in the sync group here, so PWM runs synchronized as well
  task automatic s_rspwm();
    int t1, t2;
    logic [1:0] p;
    wr(16'h131c, 32'h01);
    wr(16'h1308, 32'h06);
    wr(16'h1340, 32'h20);
    wr(16'h1354, 32'h09);
    wr(16'h1358, 32'h03);
    wr(16'h1378, 32'h06);
    wr(16'h1300, 32'h02);
    repeat (30) @(negedge ref_clk_i);
    t1 = 0;
    t2 = 0;
    p = pin_a_o[2:1];
    repeat (200)
    begin
      @(negedge ref_clk_i);
      t1 += int'(pin_a_o[1] !== p[0]);
      t2 += int'(pin_a_o[2] !== p[1]);
      p = pin_a_o[2:1];
    end
    ok("rs pwm pin 1", t1 >= 19 && t1 <= 21);
    ok("rs pwm pin 2", t2 >= 19 && t2 <= 21);
    wr(16'h1300, 32'h00);
    wr(16'h131c, 32'h00);
  endtask
  // Sources: four divided ticks and one external clock
  task automatic s_src();
    for (int s = 0; s < 5; s++)
    begin
      wr(16'h13b0, 32'h0);
      wr(16'h13a0, s);
      wr(16'h1300, 32'h10);
      repeat (128) @(posedge ref_clk_i);
      wr(16'h1300, 32'h00);
      rd(16'h13b0);
      ok("count rate", d + 32'h2 >= SE[s] && d <= SE[s] + 32'h2);
    end
  endtask
  // ==========
  // Main sequence
  initial
  begin
    rst_n_i = 1'b0;
    addr_i = 16'h0;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    s_reset();
    s_ovf();
    s_cmp();
    s_cap();
    s_sync();
    s_pwm();
    s_rspwm();
    s_src();
    report_and_stop();
  end
endmodule // test_gpt_top
